// ===== src/ddi_pkg.sv
package ddi_pkg;
	localparam int unsigned DDI_CLK_MHZ = 200;
	localparam int unsigned DDI_AW = 9;
	localparam int unsigned DDI_DW = 16;
	// config port register indices (word address bits 10:2)
	localparam logic [8:0] DDI_IDX_SOFTRST = 9'h000;
	localparam logic [8:0] DDI_IDX_MODE = 9'h001;
	localparam logic [8:0] DDI_IDX_IOCAL = 9'h002;
	localparam logic [8:0] DDI_IDX_ZQL = 9'h003;
	localparam logic [8:0] DDI_IDX_ZQS = 9'h004;
	localparam logic [8:0] DDI_IDX_ZQINT = 9'h005;
	localparam logic [8:0] DDI_IDX_TRP = 9'h006;
	localparam logic [8:0] DDI_IDX_GATE = 9'h007;
	localparam logic [8:0] DDI_IDX_EYE = 9'h008;
	localparam logic [8:0] DDI_IDX_STATUS = 9'h009;
	// field positions
	localparam int unsigned DDI_SOFTRST_BIT = 0;
	localparam int unsigned DDI_MODE_TYPE_LO = 0;
	localparam int unsigned DDI_MODE_LPCAL_BIT = 2;
	localparam int unsigned DDI_MODE_GO_BIT = 3;
	localparam int unsigned DDI_IOCAL_METH_LO = 0;
	// memory types
	localparam logic [1:0] DDI_MEM_DDR2 = 2'h0;
	localparam logic [1:0] DDI_MEM_DDR3 = 2'h1;
	localparam logic [1:0] DDI_MEM_LPDDR = 2'h2;
	// reset values
	localparam logic [15:0] DDI_RST_SOFTRST = 16'h0000;
	localparam logic [15:0] DDI_RST_MODE = 16'h0001;
	localparam logic [15:0] DDI_RST_IOCAL = 16'h0000;
	localparam logic [15:0] DDI_RST_ZQL = 16'h0200;
	localparam logic [15:0] DDI_RST_ZQS = 16'h0040;
	localparam logic [15:0] DDI_RST_ZQINT = 16'h0000;
	localparam logic [15:0] DDI_RST_TRP = 16'h0004;
	localparam logic [15:0] DDI_RST_GATE = 16'h0000;
	localparam logic [15:0] DDI_RST_EYE = 16'h0000;
	// dram command codes
	localparam logic [3:0] DDI_CMD_NOP = 4'h0;
	localparam logic [3:0] DDI_CMD_MRS = 4'h1;
	localparam logic [3:0] DDI_CMD_PREA = 4'h2;
	localparam logic [3:0] DDI_CMD_REF = 4'h3;
	localparam logic [3:0] DDI_CMD_ZQCL = 4'h4;
	localparam logic [3:0] DDI_CMD_ZQCS = 4'h5;
	// timing
	localparam int unsigned DDI_T_DRAM_RESET_US = 200;
	localparam int unsigned DDI_T_CKE_WAIT_US = 500;
	localparam int unsigned DDI_T_MRD_NS = 20;
	localparam int unsigned DDI_MRD_CYC = (DDI_T_MRD_NS * DDI_CLK_MHZ + 999) / 1000;
	// host side avalon register indices
	localparam logic [2:0] DDI_HIDX_ADDR = 3'h0;
	localparam logic [2:0] DDI_HIDX_WDATA = 3'h1;
	localparam logic [2:0] DDI_HIDX_CMD = 3'h2;
	localparam logic [2:0] DDI_HIDX_STATUS = 3'h3;
	localparam logic [2:0] DDI_HIDX_RDATA = 3'h4;
	localparam int unsigned DDI_HCMD_GO_BIT = 0;
	localparam int unsigned DDI_HCMD_WR_BIT = 1;

	typedef enum logic [7:0] {
		DDI_S_IOCAL = 8'h01,
		DDI_S_HOLD = 8'h02,
		DDI_S_DRST = 8'h04,
		DDI_S_CKE = 8'h08,
		DDI_S_MRS = 8'h10,
		DDI_S_PRECH = 8'h20,
		DDI_S_ZQ = 8'h40,
		DDI_S_ACTIVE = 8'h80
	} ddi_dev_state_t;

	typedef enum logic [2:0] {
		DDI_H_IDLE = 3'h1,
		DDI_H_SETUP = 3'h2,
		DDI_H_ACCESS = 3'h4
	} ddi_host_state_t;
endpackage

// ===== src/ddi_cfg_if.sv
`timescale 1ns/1ps
interface ddi_cfg_if;
	logic cfg_port_select_in;
	logic cfg_port_enable_in;
	logic cfg_port_write_in;
	logic [8:0] cfg_port_address;
	logic [15:0] cfg_port_write_data;
	logic [15:0] cfg_port_read_data;
	logic cfg_port_ready_out;
	logic cfg_port_error_out;

	modport device (
		input cfg_port_select_in,
		input cfg_port_enable_in,
		input cfg_port_write_in,
		input cfg_port_address,
		input cfg_port_write_data,
		output cfg_port_read_data,
		output cfg_port_ready_out,
		output cfg_port_error_out
	);

	modport host (
		output cfg_port_select_in,
		output cfg_port_enable_in,
		output cfg_port_write_in,
		output cfg_port_address,
		output cfg_port_write_data,
		input cfg_port_read_data,
		input cfg_port_ready_out,
		input cfg_port_error_out
	);
endinterface

// ===== src/ddi_device_end.sv
// What this block does
// - 16-bit read and write data on config port
// - master addresses registers with word bits 10:2
// - master raises enable in second transfer cycle
// - port drives error and ready outputs
// - software writes all config before memory use
// - init starts with reset; DDR3 adds ZQ
// - subsystem held in reset until PLL lock
// - AXI-side reset release ends reset sequence
// - soft-reset bit set places subsystem in reset
// - controller runs DRAM reset, refresh, mode registers
// - I/O calibration starts after I/Os enabled
// - calibration always on DDR2/DDR3, configurable LPDDR
// - calibration covers every I/O of bank
// - three selectable impedance setting methods
// - ZQ calibration only for DDR3 memory
// - long ZQ at init with programmable window
// - periodic short ZQ with programmable window
// - no other DRAM command during ZQ window
// - precharge all and wait tRP before ZQ
// - no dynamic leveling or training performed
// - read gate from static init delay ratios
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module ddi_device_end
	import ddi_pkg::*;
#(
	parameter int unsigned DRAM_RESET_US = DDI_T_DRAM_RESET_US,
	parameter int unsigned CKE_WAIT_US = DDI_T_CKE_WAIT_US
)(
	input wire logic clk_sys,
	input wire logic arst_n,
	ddi_cfg_if.device cfg,
	input wire logic main_pll_locked,
	input wire logic io_cal_done,
	input wire logic user_cmd_valid,
	input wire logic [3:0] user_cmd,
	output logic user_cmd_ready,
	output logic memsys_axi_reset_n,
	output logic io_enable,
	output logic io_cal_start,
	output logic [1:0] io_cal_method,
	output logic [15:0] io_cal_lane_mask,
	output logic [7:0] io_cal_fixed_code,
	output logic dram_reset_n,
	output logic dram_cke,
	output logic dram_cmd_valid,
	output logic [3:0] dram_cmd,
	output logic [1:0] dram_cmd_mr,
	output logic zq_busy,
	output logic init_done,
	output logic [15:0] read_gate_ratio,
	output logic [15:0] data_eye_ratio
);
	localparam logic [16:0] RST_CYC = 17'(DRAM_RESET_US * DDI_CLK_MHZ);
	localparam logic [16:0] CKE_CYC = 17'(CKE_WAIT_US * DDI_CLK_MHZ);
	localparam logic [16:0] MRD_CYC = 17'(DDI_MRD_CYC);

	typedef struct packed {
		ddi_dev_state_t st;
		logic [1:0] step;
		logic [16:0] cnt;
		logic [15:0] zq_int_cnt;
		logic zq_long;
		logic [15:0] softrst, mode, iocal, zql, zqs, zqint, trp, gate, eye;
		logic pready, pslverr;
		logic [15:0] prdata;
		logic axi_rst_n, io_en, cal_start, cal_en, dram_rst_n, cke, cmd_valid;
		logic [3:0] cmd;
		logic [1:0] cmd_mr;
		logic zq_busy, init_done, user_ready;
	} ddi_dev_t;

	ddi_dev_t q, n;
	logic [1:0] mem_type;
	logic is_ddr3;

	function automatic logic idx_known(input logic [8:0] a);
		return a <= DDI_IDX_STATUS;
	endfunction

	// mode registers are loaded in the order MR2, MR3, MR1, MR0
	function automatic logic [1:0] mr_order(input logic [1:0] s);
		unique case (s)
			2'h0: return 2'h2;
			2'h1: return 2'h3;
			2'h2: return 2'h1;
			default: return 2'h0;
		endcase
	endfunction

	assign mem_type = q.mode[DDI_MODE_TYPE_LO +: 2];
	assign is_ddr3 = (mem_type == DDI_MEM_DDR3);

	always_comb
	begin
		n = q;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.cal_start = 1'b0;
		n.cmd_valid = 1'b0;
		n.cmd = DDI_CMD_NOP;
		////////////////////////////////////////////////////////////////////////////////
		// config port: ready in second access cycle, one per transfer
		if (cfg.cfg_port_select_in && cfg.cfg_port_enable_in && !q.pready)
		begin
			n.pready = 1'b1;
			if (!idx_known(cfg.cfg_port_address))
				n.pslverr = 1'b1;
			else if (cfg.cfg_port_write_in)
			begin
				unique case (cfg.cfg_port_address)
					DDI_IDX_SOFTRST: n.softrst = cfg.cfg_port_write_data;
					DDI_IDX_MODE: n.mode = cfg.cfg_port_write_data;
					DDI_IDX_IOCAL: n.iocal = cfg.cfg_port_write_data;
					DDI_IDX_ZQL: n.zql = cfg.cfg_port_write_data;
					DDI_IDX_ZQS: n.zqs = cfg.cfg_port_write_data;
					DDI_IDX_ZQINT: n.zqint = cfg.cfg_port_write_data;
					DDI_IDX_TRP: n.trp = cfg.cfg_port_write_data;
					DDI_IDX_GATE: n.gate = cfg.cfg_port_write_data;
					DDI_IDX_EYE: n.eye = cfg.cfg_port_write_data;
					default: n.pslverr = 1'b1;
				endcase
			end
			else
			begin
				unique case (cfg.cfg_port_address)
					DDI_IDX_SOFTRST: n.prdata = q.softrst;
					DDI_IDX_MODE: n.prdata = q.mode;
					DDI_IDX_IOCAL: n.prdata = q.iocal;
					DDI_IDX_ZQL: n.prdata = q.zql;
					DDI_IDX_ZQS: n.prdata = q.zqs;
					DDI_IDX_ZQINT: n.prdata = q.zqint;
					DDI_IDX_TRP: n.prdata = q.trp;
					DDI_IDX_GATE: n.prdata = q.gate;
					DDI_IDX_EYE: n.prdata = q.eye;
					default: n.prdata = {5'h00, q.user_ready, q.zq_busy, q.init_done, q.st};
				endcase
			end
		end
		////////////////////////////////////////////////////////////////////////////////
		// start-up and calibration sequencer
		if (q.cnt != 17'h00000)
			n.cnt = q.cnt - 17'h00001;
		if (q.softrst[DDI_SOFTRST_BIT])
		begin
			n.st = DDI_S_HOLD;
			n.axi_rst_n = 1'b0;
			n.dram_rst_n = 1'b0;
			n.cke = 1'b0;
			n.zq_busy = 1'b0;
			n.init_done = 1'b0;
			n.user_ready = 1'b0;
		end
		else
		begin
			unique case (q.st)
				DDI_S_IOCAL:
				begin
					n.io_en = 1'b1;
					n.cal_en = (mem_type != DDI_MEM_LPDDR) || q.mode[DDI_MODE_LPCAL_BIT];
					if (q.step == 2'h0 && q.io_en)
					begin
						if (n.cal_en)
						begin
							n.cal_start = 1'b1;
							n.step = 2'h1;
						end
						else
							n.st = DDI_S_HOLD;
					end
					else if (q.step == 2'h1 && io_cal_done)
					begin
						n.step = 2'h0;
						n.st = DDI_S_HOLD;
					end
				end
				DDI_S_HOLD:
				begin
					// software sets the go bit once every register is loaded
					if (main_pll_locked && q.mode[DDI_MODE_GO_BIT])
					begin
						n.axi_rst_n = 1'b1;
						n.dram_rst_n = 1'b0;
						n.cnt = RST_CYC;
						n.zq_long = 1'b1;
						n.st = DDI_S_DRST;
					end
				end
				DDI_S_DRST:
					if (q.cnt == 17'h00000)
					begin
						n.dram_rst_n = 1'b1;
						n.cnt = CKE_CYC;
						n.st = DDI_S_CKE;
					end
				DDI_S_CKE:
					if (q.cnt == 17'h00000)
					begin
						n.cke = 1'b1;
						n.cnt = MRD_CYC;
						n.step = 2'h0;
						n.st = DDI_S_MRS;
					end
				DDI_S_MRS:
					if (q.cnt == 17'h00000)
					begin
						n.cmd_valid = 1'b1;
						n.cmd = DDI_CMD_MRS;
						n.cmd_mr = mr_order(q.step);
						n.cnt = MRD_CYC;
						n.step = q.step + 2'h1;
						if (q.step == 2'h3)
							n.st = DDI_S_PRECH;
					end
				DDI_S_PRECH:
					if (q.cnt == 17'h00000)
					begin
						if (q.step == 2'h0)
						begin
							n.cmd_valid = 1'b1;
							n.cmd = DDI_CMD_PREA;
							n.cnt = {1'b0, q.trp};
							n.step = 2'h1;
						end
						else if (is_ddr3)
						begin
							n.cmd_valid = 1'b1;
							n.cmd = q.zq_long ? DDI_CMD_ZQCL : DDI_CMD_ZQCS;
							n.cnt = {1'b0, q.zq_long ? q.zql : q.zqs};
							n.zq_busy = 1'b1;
							n.step = 2'h0;
							n.st = DDI_S_ZQ;
						end
						else
						begin
							n.cmd_valid = 1'b1;
							n.cmd = DDI_CMD_REF;
							n.init_done = 1'b1;
							n.user_ready = 1'b1;
							n.step = 2'h0;
							n.st = DDI_S_ACTIVE;
						end
					end
				DDI_S_ZQ:
					// leave one count early so the next command lands exactly the window after
					if (q.cnt <= 17'h00001)
					begin
						n.zq_busy = 1'b0;
						if (!q.init_done)
						begin
							n.cmd_valid = 1'b1;
							n.cmd = DDI_CMD_REF;
						end
						n.init_done = 1'b1;
						n.user_ready = 1'b1;
						n.zq_int_cnt = q.zqint;
						n.st = DDI_S_ACTIVE;
					end
				DDI_S_ACTIVE:
				begin
					// static gate and eye ratios only; no training states exist
					if (user_cmd_valid && q.user_ready)
					begin
						n.cmd_valid = 1'b1;
						n.cmd = user_cmd;
					end
					if (is_ddr3 && q.zqint != 16'h0000)
					begin
						if (q.zq_int_cnt == 16'h0000)
						begin
							n.user_ready = 1'b0;
							n.zq_long = 1'b0;
							n.step = 2'h0;
							n.cnt = 17'h00000;
							n.st = DDI_S_PRECH;
						end
						else
							n.zq_int_cnt = q.zq_int_cnt - 16'h0001;
					end
				end
				default: n.st = DDI_S_HOLD;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			q <= '0;
			q.st <= DDI_S_IOCAL;
			q.softrst <= DDI_RST_SOFTRST;
			q.mode <= DDI_RST_MODE;
			q.iocal <= DDI_RST_IOCAL;
			q.zql <= DDI_RST_ZQL;
			q.zqs <= DDI_RST_ZQS;
			q.zqint <= DDI_RST_ZQINT;
			q.trp <= DDI_RST_TRP;
			q.gate <= DDI_RST_GATE;
			q.eye <= DDI_RST_EYE;
		end
		else
			q <= n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign cfg.cfg_port_ready_out = q.pready;
	assign cfg.cfg_port_error_out = q.pslverr;
	assign cfg.cfg_port_read_data = q.prdata;
	assign user_cmd_ready = q.user_ready;
	assign memsys_axi_reset_n = q.axi_rst_n;
	assign io_enable = q.io_en;
	assign io_cal_start = q.cal_start;
	assign io_cal_method = q.iocal[DDI_IOCAL_METH_LO +: 2];
	assign io_cal_lane_mask = {16{q.cal_en}};
	assign io_cal_fixed_code = q.iocal[15:8];
	assign dram_reset_n = q.dram_rst_n;
	assign dram_cke = q.cke;
	assign dram_cmd_valid = q.cmd_valid;
	assign dram_cmd = q.cmd;
	assign dram_cmd_mr = q.cmd_mr;
	assign zq_busy = q.zq_busy;
	assign init_done = q.init_done;
	assign read_gate_ratio = q.gate;
	assign data_eye_ratio = q.eye;
endmodule // ddi_device_end

// ===== src/ddi_host_end.sv
`timescale 1ns/1ps
module ddi_host_end
	import ddi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	ddi_cfg_if.host cfg,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	typedef struct packed {
		ddi_host_state_t st;
		logic [8:0] addr;
		logic [15:0] wdata, rdata;
		logic wr, err;
		logic psel, penable, pwrite;
		logic [8:0] paddr;
		logic [15:0] pwdata;
		logic waitreq;
		logic [31:0] readdata;
	} ddi_host_t;

	ddi_host_t q, n;

	always_comb
	begin
		n = q;
		////////////////////////////////////////////////////////////////////////////////
		// avalon slave: one wait state, then one cycle with waitrequest low
		n.waitreq = 1'b1;
		// reads are answered from the first edge, writes land on the closing edge
		if ((avs_read || avs_write) && q.waitreq)
		begin
			n.waitreq = 1'b0;
			n.readdata = 32'h00000000;
			if (avs_read)
			begin
				unique case (avs_address)
					DDI_HIDX_ADDR: n.readdata = {23'h000000, q.addr};
					DDI_HIDX_WDATA: n.readdata = {16'h0000, q.wdata};
					DDI_HIDX_CMD: n.readdata = {30'h00000000, q.wr, 1'b0};
					DDI_HIDX_STATUS: n.readdata = {30'h00000000, q.err, q.st != DDI_H_IDLE};
					DDI_HIDX_RDATA: n.readdata = {16'h0000, q.rdata};
					default: n.readdata = 32'h00000000;
				endcase
			end
		end
		else if (avs_write && !q.waitreq)
		begin
			begin
				unique case (avs_address)
					DDI_HIDX_ADDR: n.addr = avs_writedata[8:0];
					DDI_HIDX_WDATA: n.wdata = avs_writedata[15:0];
					DDI_HIDX_CMD:
						if (avs_writedata[DDI_HCMD_GO_BIT] && q.st == DDI_H_IDLE)
						begin
							n.wr = avs_writedata[DDI_HCMD_WR_BIT];
							n.psel = 1'b1;
							n.pwrite = avs_writedata[DDI_HCMD_WR_BIT];
							n.paddr = q.addr;
							n.pwdata = q.wdata;
							n.err = 1'b0;
							n.st = DDI_H_SETUP;
						end
					default: n.addr = q.addr;
				endcase
			end
		end
		////////////////////////////////////////////////////////////////////////////////
		// config port master
		unique case (q.st)
			DDI_H_IDLE: n.penable = 1'b0;
			DDI_H_SETUP:
			begin
				n.penable = 1'b1;
				n.st = DDI_H_ACCESS;
			end
			DDI_H_ACCESS:
				if (cfg.cfg_port_ready_out)
				begin
					n.psel = 1'b0;
					n.penable = 1'b0;
					n.err = cfg.cfg_port_error_out;
					if (!q.pwrite)
						n.rdata = cfg.cfg_port_read_data;
					n.st = DDI_H_IDLE;
				end
			default: n.st = DDI_H_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			q <= '0;
			q.st <= DDI_H_IDLE;
			q.waitreq <= 1'b1;
		end
		else
			q <= n;
	end

	assign cfg.cfg_port_select_in = q.psel;
	assign cfg.cfg_port_enable_in = q.penable;
	assign cfg.cfg_port_write_in = q.pwrite;
	assign cfg.cfg_port_address = q.paddr;
	assign cfg.cfg_port_write_data = q.pwdata;
	assign avs_readdata = q.readdata;
	assign avs_waitrequest = q.waitreq;
endmodule // ddi_host_end

// ===== test/ddi_properties.sv
`timescale 1ns/1ps
module ddi_properties
	import ddi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic cfg_port_select_in,
	input wire logic cfg_port_enable_in,
	input wire logic cfg_port_write_in,
	input wire logic [8:0] cfg_port_address,
	input wire logic [15:0] cfg_port_write_data,
	input wire logic [15:0] cfg_port_read_data,
	input wire logic cfg_port_ready_out,
	input wire logic cfg_port_error_out
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////////////
	sequence setup_s;
		cfg_port_select_in && !cfg_port_enable_in;
	endsequence
	sequence access_s;
		cfg_port_select_in && cfg_port_enable_in && !cfg_port_ready_out;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	ready_pulse_a: assert property (cfg_port_ready_out |=> !cfg_port_ready_out)
		else $error("ready high two cycles");
	access_answer_a: assert property (access_s |=> cfg_port_ready_out)
		else $error("no ready after access");
	transfer_close_a: assert property (setup_s ##1 access_s |=> cfg_port_ready_out ##1 !cfg_port_enable_in)
		else $error("transfer not closed");
	setup_enable_a: assert property (setup_s |=> cfg_port_enable_in)
		else $error("enable missing after setup");
	enable_after_sel_a: assert property ($rose(cfg_port_enable_in) |-> $past(cfg_port_select_in))
		else $error("enable without setup");
	ready_in_access_a: assert property (cfg_port_ready_out |-> cfg_port_select_in && cfg_port_enable_in)
		else $error("ready outside access");
	error_with_ready_a: assert property (cfg_port_error_out |-> cfg_port_ready_out)
		else $error("error without ready");
	request_hold_a: assert property (cfg_port_enable_in |-> $stable(cfg_port_address)
		&& $stable(cfg_port_write_in) && $stable(cfg_port_write_data))
		else $error("request changed in access");
	bad_index_a: assert property (cfg_port_select_in && cfg_port_enable_in && !cfg_port_ready_out
		&& cfg_port_address > 9'h009 |=> cfg_port_error_out)
		else $error("no error on bad index");
	good_index_a: assert property (cfg_port_select_in && cfg_port_enable_in && !cfg_port_ready_out
		&& cfg_port_address < 9'h009 |=> !cfg_port_error_out)
		else $error("error on mapped index");
	read_hold_a: assert property ($changed(cfg_port_read_data)
		|-> cfg_port_ready_out && !cfg_port_write_in)
		else $error("read data moved");
endmodule // ddi_properties

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import ddi_pkg::*;
;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic main_pll_locked = 1'b0;
	logic io_cal_done = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, memsys_axi_reset_n, dram_reset_n, dram_cmd_valid, zq_busy;
	logic user_cmd_ready, init_done, io_enable, io_cal_start, cal_seen;
	logic [1:0] io_cal_method;
	logic [15:0] io_cal_lane_mask, read_gate_ratio;
	logic [7:0] io_cal_fixed_code;
	logic [3:0] dram_cmd;
	logic user_cmd_valid = 1'b0;
	logic [3:0] user_cmd = 4'h0;
	logic dram_cke;
	logic [1:0] dram_cmd_mr;
	logic [15:0] data_eye_ratio;
	logic [3:0] cmd_q[$];
	int t_q[$];
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int busy_n = 0;
	////////////////////////////////////////////////////////////////////////////////
	ddi_cfg_if cfg_bus();
	ddi_host_end ddi_host_end_inst (
		.clk_sys, .arst_n, .cfg(cfg_bus.host), .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest
	);
	ddi_device_end #(
		.DRAM_RESET_US(1),
		.CKE_WAIT_US(1)
	) ddi_device_end_inst (
		.clk_sys, .arst_n, .cfg(cfg_bus.device), .main_pll_locked, .io_cal_done,
		.user_cmd_valid, .user_cmd, .user_cmd_ready, .memsys_axi_reset_n,
		.io_enable, .io_cal_start, .io_cal_method, .io_cal_lane_mask, .io_cal_fixed_code,
		.dram_reset_n, .dram_cke, .dram_cmd_valid, .dram_cmd, .dram_cmd_mr, .zq_busy,
		.init_done, .read_gate_ratio, .data_eye_ratio
	);
	ddi_properties ddi_properties_inst (
		.clk_sys, .arst_n,
		.cfg_port_select_in(cfg_bus.cfg_port_select_in),
		.cfg_port_enable_in(cfg_bus.cfg_port_enable_in),
		.cfg_port_write_in(cfg_bus.cfg_port_write_in),
		.cfg_port_address(cfg_bus.cfg_port_address),
		.cfg_port_write_data(cfg_bus.cfg_port_write_data),
		.cfg_port_read_data(cfg_bus.cfg_port_read_data),
		.cfg_port_ready_out(cfg_bus.cfg_port_ready_out),
		.cfg_port_error_out(cfg_bus.cfg_port_error_out)
	);
	always #2.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// command log and hang guard
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (dram_cmd_valid === 1'b1)
		begin
			cmd_q.push_back(dram_cmd);
			t_q.push_back(cyc);
		end
		if (zq_busy === 1'b1)
			busy_n++;
		if (io_cal_start === 1'b1)
			cal_seen = (io_enable === 1'b1);
		if (cyc > 20000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic avs(input logic wr, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic cfg(input logic wr, input logic [8:0] idx, input logic [15:0] d,
		output logic [15:0] rd, output logic er);
		logic [31:0] q;
		avs(1'b1, DDI_HIDX_ADDR, {23'h0, idx}, q);
		avs(1'b1, DDI_HIDX_WDATA, {16'h0, d}, q);
		avs(1'b1, DDI_HIDX_CMD, {30'h0, wr, 1'b1}, q);
		do
			avs(1'b0, DDI_HIDX_STATUS, 32'h0, q);
		while (q[0] !== 1'b0);
		er = q[1];
		avs(1'b0, DDI_HIDX_RDATA, 32'h0, q);
		rd = q[15:0];
	endtask
	task automatic wreg(input logic [8:0] idx, input logic [15:0] d);
		logic [15:0] rd;
		logic er;
		cfg(1'b1, idx, d, rd, er);
		chk("write error", er, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [15:0] rv[9] = '{DDI_RST_SOFTRST, DDI_RST_MODE, DDI_RST_IOCAL, DDI_RST_ZQL,
			DDI_RST_ZQS, DDI_RST_ZQINT, DDI_RST_TRP, DDI_RST_GATE, DDI_RST_EYE};
		logic [15:0] rd;
		logic er;
		logic [31:0] q;
		for (int i = 0; i < 9; i++)
		begin
			cfg(1'b0, i[8:0], 16'h0000, rd, er);
			chk("reset value", rd, rv[i]);
		end
		cfg(1'b0, 9'h00A, 16'h0000, rd, er);
		chk("bad index error", er, 1'b1);
		cfg(1'b1, DDI_IDX_STATUS, 16'h1234, rd, er);
		chk("status write error", er, 1'b1);
		cfg(1'b0, DDI_IDX_STATUS, 16'h0000, rd, er);
		chk("calibration state", rd[7:0], 8'h01);
		chk("cal after io enable", cal_seen, 1'b1);
		chk("axi reset before lock", memsys_axi_reset_n, 1'b0);
		avs(1'b0, 3'h7, 32'h0, q);
		chk("unmapped host read", q, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_iocal();
		logic [15:0] mv[4] = '{16'h0002, 16'h0006, 16'h0000, 16'h0001};
		logic [15:0] mk[4] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF};
		for (int m = 0; m < 3; m++)
		begin
			wreg(DDI_IDX_IOCAL, {8'hA5, 6'h00, m[1:0]});
			chk("cal method", io_cal_method, m[1:0]);
			chk("fixed code", io_cal_fixed_code, 8'hA5);
		end
		for (int i = 0; i < 4; i++)
		begin
			wreg(DDI_IDX_MODE, mv[i]);
			chk("lane mask", io_cal_lane_mask, mk[i]);
		end
		$display("test iocal done");
	endtask
	task automatic t_init();
		logic [3:0] ev[7] = '{DDI_CMD_MRS, DDI_CMD_MRS, DDI_CMD_MRS, DDI_CMD_MRS,
			DDI_CMD_PREA, DDI_CMD_ZQCL, DDI_CMD_REF};
		logic [15:0] rd;
		logic er;
		wreg(DDI_IDX_ZQL, 16'h0010);
		wreg(DDI_IDX_TRP, 16'h0005);
		wreg(DDI_IDX_GATE, 16'h0123);
		wreg(DDI_IDX_EYE, 16'h0456);
		wreg(DDI_IDX_MODE, 16'h0009);
		io_cal_done <= 1'b1;
		cfg(1'b0, DDI_IDX_STATUS, 16'h0000, rd, er);
		chk("hold state", rd[7:0], 8'h02);
		chk("axi reset held", memsys_axi_reset_n, 1'b0);
		chk("early command", cmd_q.size(), 0);
		main_pll_locked <= 1'b1;
		while (init_done !== 1'b1)
			@(posedge clk_sys);
		// let the command log take the closing refresh first
		@(posedge clk_sys);
		chk("axi reset released", memsys_axi_reset_n, 1'b1);
		chk("clock enable", dram_cke, 1'b1);
		chk("last mode register", dram_cmd_mr, 2'h0);
		chk("eye ratio", data_eye_ratio, 16'h0456);
		chk("command count", cmd_q.size(), 7);
		for (int i = 0; i < 7 && i < cmd_q.size(); i++)
			chk("init command", cmd_q[i], ev[i]);
		chk("precharge gap", t_q[5] - t_q[4] >= 5, 1'b1);
		chk("long window gap", t_q[6] - t_q[5] >= 16, 1'b1);
		chk("long window", busy_n, 16);
		chk("gate ratio", read_gate_ratio, 16'h0123);
		$display("test init done");
	endtask
	task automatic t_periodic();
		cmd_q.delete();
		t_q.delete();
		busy_n = 0;
		wreg(DDI_IDX_ZQS, 16'h0008);
		wreg(DDI_IDX_ZQINT, 16'h0020);
		while (cmd_q.size() < 2)
			@(posedge clk_sys);
		chk("ready in short window", user_cmd_ready, 1'b0);
		wreg(DDI_IDX_ZQINT, 16'h0000);
		while (user_cmd_ready !== 1'b1)
			@(posedge clk_sys);
		chk("short count", cmd_q.size(), 2);
		chk("short precharge", cmd_q[0], DDI_CMD_PREA);
		chk("short command", cmd_q[1], DDI_CMD_ZQCS);
		chk("short gap", t_q[1] - t_q[0] >= 5, 1'b1);
		chk("short window", busy_n, 8);
		$display("test periodic done");
	endtask
	task automatic t_soft();
		wreg(DDI_IDX_SOFTRST, 16'h0001);
		chk("soft axi reset", memsys_axi_reset_n, 1'b0);
		chk("soft dram reset", dram_reset_n, 1'b0);
		wreg(DDI_IDX_MODE, 16'h0008);
		cmd_q.delete();
		t_q.delete();
		wreg(DDI_IDX_SOFTRST, 16'h0000);
		while (init_done !== 1'b1)
			@(posedge clk_sys);
		@(posedge clk_sys);
		chk("ddr2 count", cmd_q.size(), 6);
		chk("ddr2 last", cmd_q[5], DDI_CMD_REF);
		chk("soft release", memsys_axi_reset_n, 1'b1);
		cmd_q.delete();
		user_cmd <= DDI_CMD_REF;
		user_cmd_valid <= 1'b1;
		@(posedge clk_sys);
		user_cmd_valid <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("user command count", cmd_q.size(), 1);
		chk("user command", cmd_q[0], DDI_CMD_REF);
		$display("test soft done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_iocal();
		t_init();
		t_periodic();
		t_soft();
		report_and_stop();
	end
endmodule // tb_top
